/* include/swg_pkg.sv */
// Package of constants and carrier types for the wait-state generator.
package swg_pkg;
  // Printed offsets are not all multiples of four: they are word indices.
  localparam logic [7:0] WAIT_COUNT_SELECT_IDX = 8'h28;
  localparam logic [7:0] WAIT_MULTIPLIER_CONFIG_IDX = 8'h2b;
  localparam logic [15:0] WAIT_COUNT_SELECT_RST = 16'h7fff;
  localparam logic [15:0] WAIT_MULTIPLIER_CONFIG_RST = 16'h0000;
  localparam int XPA_POS = 15;
  localparam int IO_POS = 12;
  localparam int DATA_HI_POS = 9;
  localparam int DATA_LO_POS = 6;
  localparam int PROG_HI_POS = 3;
  localparam int PROG_LO_POS = 0;
  localparam int DOUBLING_POS = 0;
  localparam int FIELD_W = 3;
  localparam int ADDR_W = 23;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SWG_SPACE_PROG,
    SWG_SPACE_DATA,
    SWG_SPACE_IO
  } swg_space_t;

  // One external access request from the CPU side.
  typedef struct packed {
    logic valid;
    swg_space_t space;
    logic [ADDR_W-1:0] addr;
  } swg_req_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } swg_axi_in_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } swg_axi_out_t;
endpackage

/* rtl/swg_counter.sv */
// Down counter that stretches one access by a loaded number of cycles.
`timescale 1ns/100ps
module swg_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [3:0] count,
  input wire logic ready_in,
  output logic busy
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;

  assign busy = busy_r;

  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    if (load) begin
      cnt_nxt = count;
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      if (cnt_r != 4'h0) begin
        cnt_nxt = cnt_r - 4'h1;
      end else if (ready_in) begin
        busy_nxt = 1'b0;
      end
    end
  end

  // The enable models a gated clock: with every count at zero the counter
  // holds still and only the ready line can stretch an access.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
    end else if (clk_en || load || busy_r) begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end
endmodule

/* rtl/swg_top.sv */
// Software wait-state generator with an AXI4-Lite register slave.
//
// Operation
// - Each external access can be stretched by up to fourteen cycles.
// - All counts zero gates off the counter clock to save power.
// - Low fifteen bits hold five three-bit base counts, one per range.
// - After reset every external access gets seven wait states.
// - Bit 15 selects the extended program range and resets to zero.
// - Bits 14 to 12 set the count for all I/O accesses.
// - Bits 11 to 9 set the count for data with address bit 15 set.
// - Bits 8 to 6 set the count for data up to 7FFFh.
// - Bits 5 to 3 cover program page upper half unless extended.
// - Bits 2 to 0 cover a program range set by the extended bit.
// - Doubling bit zero keeps counts; one doubles them to fourteen.
// - Configuration bits 15 to 1 read zero and ignore writes.
`timescale 1ns/100ps
module swg_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire swg_pkg::swg_axi_in_t axi_in,
  output swg_pkg::swg_axi_out_t axi_out,
  input wire swg_pkg::swg_req_t req,
  input wire logic ready_in,
  output logic access_wait,
  output logic access_done,
  output logic [3:0] wait_count,
  output logic gen_clk_en
);
  logic [15:0] wait_count_select_r;
  logic [15:0] wait_count_select_nxt;
  logic wait_doubling_bit_r;
  logic wait_doubling_bit_nxt;

  logic aw_held_r;
  logic aw_held_nxt;
  logic [7:0] awaddr_r;
  logic [7:0] awaddr_nxt;
  logic w_held_r;
  logic w_held_nxt;
  logic [31:0] wdata_r;
  logic [31:0] wdata_nxt;
  logic [3:0] wstrb_r;
  logic [3:0] wstrb_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic awready_r;
  logic awready_nxt;
  logic wready_r;
  logic wready_nxt;
  logic arready_r;
  logic arready_nxt;

  logic access_done_r;
  logic access_done_nxt;
  logic [3:0] wait_count_r;
  logic [3:0] wait_count_nxt;
  logic gen_clk_en_r;
  logic gen_clk_en_nxt;
  logic busy;
  logic busy_d_r;
  logic [2:0] base_sel;
  logic [3:0] scaled;
  logic all_zero;
  logic do_write;
  logic [7:0] rd_idx;

  always_comb begin
    axi_out.awready = awready_r;
    axi_out.wready = wready_r;
    axi_out.bresp = bresp_r;
    axi_out.bvalid = bvalid_r;
    axi_out.arready = arready_r;
    axi_out.rdata = rdata_r;
    axi_out.rresp = rresp_r;
    axi_out.rvalid = rvalid_r;
  end

  assign access_wait = busy;
  assign access_done = access_done_r;
  assign wait_count = wait_count_r;
  assign gen_clk_en = gen_clk_en_r;

  // Range decode: pick the three-bit base count for the request.
  always_comb begin
    base_sel = 3'h0;
    unique case (req.space)
      swg_pkg::SWG_SPACE_IO: begin
        base_sel = wait_count_select_r[swg_pkg::IO_POS +:
                                       swg_pkg::FIELD_W];
      end
      swg_pkg::SWG_SPACE_DATA: begin
        if (req.addr[15]) begin
          base_sel = wait_count_select_r[swg_pkg::DATA_HI_POS +:
                                         swg_pkg::FIELD_W];
        end else begin
          base_sel = wait_count_select_r[swg_pkg::DATA_LO_POS +:
                                         swg_pkg::FIELD_W];
        end
      end
      swg_pkg::SWG_SPACE_PROG: begin
        if (!wait_count_select_r[swg_pkg::XPA_POS] && req.addr[15]) begin
          base_sel = wait_count_select_r[swg_pkg::PROG_HI_POS +:
                                         swg_pkg::FIELD_W];
        end else begin
          base_sel = wait_count_select_r[swg_pkg::PROG_LO_POS +:
                                         swg_pkg::FIELD_W];
        end
      end
      default: begin
        base_sel = 3'h0;
      end
    endcase
  end

  // Doubling gives at most 14 wait cycles on top of the access itself.
  assign scaled = wait_doubling_bit_r ? {base_sel, 1'b0}
                                      : {1'b0, base_sel};

  // The upper program field is ignored in extended mode, so it does not
  // keep the counter clock running there.
  assign all_zero = (wait_count_select_r[14:6] == 9'h000) &&
                    (wait_count_select_r[2:0] == 3'h0) &&
                    (wait_count_select_r[swg_pkg::XPA_POS] ||
                     wait_count_select_r[5:3] == 3'h0);

  swg_counter u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(gen_clk_en_r),
    .load(req.valid && !busy),
    .count(scaled),
    .ready_in(ready_in),
    .busy(busy)
  );

  always_comb begin
    gen_clk_en_nxt = !all_zero;
    wait_count_nxt = wait_count_r;
    if (req.valid && !busy) begin
      wait_count_nxt = scaled;
    end
    access_done_nxt = busy_d_r && !busy;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_clk_en_r <= 1'b1;
      wait_count_r <= 4'h0;
      access_done_r <= 1'b0;
      busy_d_r <= 1'b0;
    end else begin
      gen_clk_en_r <= gen_clk_en_nxt;
      wait_count_r <= wait_count_nxt;
      access_done_r <= access_done_nxt;
      busy_d_r <= busy;
    end
  end

  // AXI4-Lite slave: address and data are taken in either order.
  assign rd_idx = axi_in.araddr;

  always_comb begin
    aw_held_nxt = aw_held_r;
    awaddr_nxt = awaddr_r;
    w_held_nxt = w_held_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    wait_count_select_nxt = wait_count_select_r;
    wait_doubling_bit_nxt = wait_doubling_bit_r;
    do_write = 1'b0;
    if (axi_in.awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = {2'b00, axi_in.awaddr[7:2]};
    end
    if (axi_in.wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt = axi_in.wdata;
      wstrb_nxt = axi_in.wstrb;
    end
    if (bvalid_r && axi_in.bready) begin
      bvalid_nxt = 1'b0;
    end
    // Both halves must be in hand, from this edge or held from earlier.
    do_write = aw_held_nxt && w_held_nxt && !bvalid_r;
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = swg_pkg::AXI_OKAY;
      if (awaddr_nxt == swg_pkg::WAIT_COUNT_SELECT_IDX) begin
        if (wstrb_nxt[0]) begin
          wait_count_select_nxt[7:0] = wdata_nxt[7:0];
        end
        if (wstrb_nxt[1]) begin
          wait_count_select_nxt[15:8] = wdata_nxt[15:8];
        end
      end else if (awaddr_nxt == swg_pkg::WAIT_MULTIPLIER_CONFIG_IDX) begin
        if (wstrb_nxt[0]) begin
          wait_doubling_bit_nxt = wdata_nxt[swg_pkg::DOUBLING_POS];
        end
      end else begin
        bresp_nxt = swg_pkg::AXI_SLVERR;
      end
    end
    if (rvalid_r && axi_in.rready) begin
      rvalid_nxt = 1'b0;
    end
    if (axi_in.arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = swg_pkg::AXI_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (rd_idx[7:2] == swg_pkg::WAIT_COUNT_SELECT_IDX[5:0]) begin
        rdata_nxt = {16'h0000, wait_count_select_r};
      end else if (rd_idx[7:2] == swg_pkg::WAIT_MULTIPLIER_CONFIG_IDX[5:0])
      begin
        rdata_nxt = {31'h0000_0000, wait_doubling_bit_r};
      end else begin
        rresp_nxt = swg_pkg::AXI_SLVERR;
      end
    end
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt = !w_held_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_count_select_r <= swg_pkg::WAIT_COUNT_SELECT_RST;
      wait_doubling_bit_r <= swg_pkg::WAIT_MULTIPLIER_CONFIG_RST[0];
      aw_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'b00;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
    end else begin
      wait_count_select_r <= wait_count_select_nxt;
      wait_doubling_bit_r <= wait_doubling_bit_nxt;
      aw_held_r <= aw_held_nxt;
      awaddr_r <= awaddr_nxt;
      w_held_r <= w_held_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end
endmodule

/* testbench/swg_chk_sva.sv */
// Checker on the wait-state generator ports.
`timescale 1ns/100ps
module swg_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire swg_pkg::swg_axi_in_t axi_in,
  input wire swg_pkg::swg_axi_out_t axi_out,
  input wire swg_pkg::swg_req_t req,
  input wire logic ready_in,
  input wire logic access_wait,
  input wire logic access_done,
  input wire logic [3:0] wait_count,
  input wire logic gen_clk_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  take_req_a: assert property (
    req.valid && !access_wait |=> access_wait)
    else $error("request not taken");
  ready_hold_a: assert property (
    access_wait && !ready_in |=> access_wait)
    else $error("wait ended while not ready");
  wait_max_a: assert property (access_wait |-> wait_count <= 4'hE)
    else $error("wait count above fourteen");
  done_after_a: assert property (
    $fell(access_wait) |-> ##[0:1] access_done)
    else $error("no done pulse");
  done_pulse_a: assert property (access_done |=> !access_done)
    else $error("done longer than one cycle");
  ar_answer_a: assert property (
    axi_in.arvalid && axi_out.arready |=> axi_out.rvalid)
    else $error("read answer late");
  rd_block_a: assert property (axi_out.rvalid |-> !axi_out.arready)
    else $error("read taken while pending");
  rd_upper_a: assert property (
    axi_out.rvalid |-> axi_out.rdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
endmodule

/* testbench/swg_ext_mem.sv */
// External device model that holds off accesses with ready.
`timescale 1ns/100ps
module swg_ext_mem (
  input wire logic aclk,
  input wire logic [3:0] stall,
  input wire logic access_wait,
  output logic ready_in
);
  logic [3:0] cnt_r = 4'h0;
  // Loaded while idle, so the stall counts from the first wait cycle.
  always_ff @(posedge aclk) begin
    if (!access_wait) cnt_r <= stall;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
  assign ready_in = (cnt_r == 4'h0);
endmodule

/* testbench/swg_tb_top.sv */
// Self-checking bench for the wait-state generator.
`timescale 1ns/100ps
module swg_tb_top;
  localparam logic [7:0] RA = swg_pkg::WAIT_COUNT_SELECT_IDX << 2;
  localparam logic [7:0] RC = swg_pkg::WAIT_MULTIPLIER_CONFIG_IDX << 2;
  logic aclk, aresetn, ready_in, access_wait, access_done, gen_clk_en;
  logic [3:0] wait_count, stall;
  swg_pkg::swg_axi_in_t ai;
  swg_pkg::swg_axi_out_t ao;
  swg_pkg::swg_req_t rq;
  int num_errors, checks_done;
  swg_top dut_u (.aclk(aclk), .aresetn(aresetn), .axi_in(ai), .axi_out(ao),
    .req(rq), .ready_in(ready_in), .access_wait(access_wait),
    .access_done(access_done), .wait_count(wait_count),
    .gen_clk_en(gen_clk_en));
  swg_ext_mem mem_u (.aclk(aclk), .stall(stall), .access_wait(access_wait),
    .ready_in(ready_in));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  function automatic logic [3:0] ecnt(input logic [15:0] w, input logic m,
    input swg_pkg::swg_space_t s, input logic [22:0] a);
    logic [2:0] f;
    case (s)
      swg_pkg::SWG_SPACE_IO: f = w[14:12];
      swg_pkg::SWG_SPACE_DATA: f = a[15] ? w[11:9] : w[8:6];
      default: f = (a[15] && !w[15]) ? w[5:3] : w[2:0];
    endcase
    return m ? {f, 1'b0} : {1'b0, f};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
    output logic [1:0] r);
    ai.awaddr <= a;
    ai.wdata <= {16'h0000, d};
    ai.awvalid <= 1'b1;
    ai.wvalid <= 1'b1;
    ai.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (ao.awready) ai.awvalid <= 1'b0;
      if (ao.wready) ai.wvalid <= 1'b0;
    end while (!ao.bvalid);
    r = ao.bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    ai.araddr <= a;
    ai.arvalid <= 1'b1;
    ai.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (ao.arready) ai.arvalid <= 1'b0;
    end while (!ao.rvalid);
    d = ao.rdata;
    r = ao.rresp;
  endtask
  task automatic acc(input swg_pkg::swg_space_t s, input logic [22:0] a,
    input logic [3:0] ec, input logic [3:0] st);
    int n;
    n = 0;
    stall <= st;
    rq <= '{1'b1, s, a};
    @(posedge aclk);
    rq.valid <= 1'b0;
    repeat (40) begin
      @(posedge aclk);
      if (access_wait) n++;
      else if (n > 0) break;
    end
    chk(wait_count, ec);
    chk(n, (ec > st ? ec : st) + 1);
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] w;
    logic m;
    logic [22:0] a;
    swg_pkg::swg_space_t s;
    logic [3:0] e;
    num_errors = 0;
    checks_done = 0;
    stall = 4'h0;
    ai = '0;
    ai.wstrb = 4'hf;
    rq = '0;
    aresetn = 1'b0;
    void'($urandom(32'h049c_2d61));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(RA, d, r);
    chk(d, 32'h0000_7fff);
    rd(RC, d, r);
    chk(d, 32'h0000_0000);
    for (int i = 0; i < 3; i++)
      acc(swg_pkg::swg_space_t'(i), 23'h00_8000, 4'h7, 4'h0);
    $display("test reset done");
    wr(RC, 16'hffff, r);
    rd(RC, d, r);
    chk(d, 32'h0000_0001);
    wr(8'h00, 16'h1234, r);
    chk(r, swg_pkg::AXI_SLVERR);
    $display("test registers done");
    for (int i = 0; i < 14; i++) begin
      w = (i == 0) ? 16'h7fff : (i == 1) ? 16'h0000 : 16'($urandom);
      if (i == 2) w = 16'h8038;
      m = (i == 0) ? 1'b1 : 1'($urandom);
      a = 23'($urandom);
      s = swg_pkg::swg_space_t'($urandom % 3);
      if (i == 2) begin
        s = swg_pkg::SWG_SPACE_PROG;
        a[15] = 1'b1;
      end
      e = ecnt(w, m, s, a);
      wr(RA, w, r);
      chk(r, swg_pkg::AXI_OKAY);
      wr(RC, {15'h0000, m}, r);
      rd(RA, d, r);
      chk(d, {16'h0000, w});
      chk(r, swg_pkg::AXI_OKAY);
      acc(s, a, e, 4'($urandom % 4));
      chk(wait_count, e);
      chk(gen_clk_en, w[15] ? |{w[14:6], w[2:0]} : |w[14:0]);
    end
    $display("test random done");
    stop_test();
  end
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end
endmodule
bind swg_top swg_chk chk_u (.aclk(aclk), .aresetn(aresetn),
  .axi_in(axi_in), .axi_out(axi_out), .req(req), .ready_in(ready_in),
  .access_wait(access_wait), .access_done(access_done),
  .wait_count(wait_count), .gen_clk_en(gen_clk_en));
